// >>> core/vout_regs_pkg.sv
// constants shared by the output voltage trim and ceiling register bank
`default_nettype none
package vout_regs_pkg;
  localparam int NUM_PAGES = 2;
  localparam int PAGE_W = 1;
  localparam int DATA_W = 16;
  localparam int CMD_W = 8;
  // command codes of the two paged words
  localparam logic [CMD_W-1:0] CMD_TRIM_OFFSET = 8'h22;
  localparam logic [CMD_W-1:0] CMD_TARGET_CEILING = 8'h24;
  // values after reset
  localparam logic [DATA_W-1:0] TRIM_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CEILING_RESET = 16'h08FC;
  // trim span in millivolts, one count per millivolt
  localparam int TRIM_SPAN_MV = 250;
  localparam logic signed [DATA_W+1:0] TRIM_MAX = 18'(TRIM_SPAN_MV);
  localparam logic signed [DATA_W+1:0] TRIM_MIN = -18'(TRIM_SPAN_MV);
  // cycles from a register write to the target output
  localparam int TARGET_LATENCY = 1;
endpackage : vout_regs_pkg
`default_nettype wire

// >>> core/target_calc_if.sv
// carries per-page register values and command into the target limiter and the result back
`timescale 1ns/1ps
`default_nettype none
interface target_calc_if;
  import vout_regs_pkg::*;
  logic [NUM_PAGES-1:0][DATA_W-1:0] command;
  logic [NUM_PAGES-1:0][DATA_W-1:0] trim;
  logic [NUM_PAGES-1:0][DATA_W-1:0] ceiling;
  logic [NUM_PAGES-1:0][DATA_W-1:0] target;
  modport regs (output command, output trim, output ceiling, input target);
  modport calc (input command, input trim, input ceiling, output target);
endinterface : target_calc_if
`default_nettype wire

// >>> core/target_limiter.sv
// forms command plus trim per page and holds it between zero and the ceiling
`timescale 1ns/1ps
`default_nettype none
module target_limiter
  import vout_regs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  target_calc_if.calc calc
);

  // trim beyond the span is clipped, not wrapped, so a bad write cannot swing the rail
  function automatic logic [DATA_W-1:0] limit_target(input logic [DATA_W-1:0] cmd,
                                                     input logic [DATA_W-1:0] trim,
                                                     input logic [DATA_W-1:0] ceil);
    logic signed [DATA_W+1:0] t;
    logic signed [DATA_W+1:0] sum;
    t = signed'({{2{trim[DATA_W-1]}}, trim});
    if (t > TRIM_MAX) t = TRIM_MAX;
    if (t < TRIM_MIN) t = TRIM_MIN;
    sum = signed'({2'b00, cmd}) + t;
    if (sum < 0) return '0;
    if (sum > signed'({2'b00, ceil})) return ceil;
    return sum[DATA_W-1:0];
  endfunction : limit_target

  logic [NUM_PAGES-1:0][DATA_W-1:0] next_target;

  for (genvar p = 0; p < NUM_PAGES; p++) begin : g_page
    assign next_target[p] = limit_target(calc.command[p], calc.trim[p], calc.ceiling[p]);
  end

  always_ff @(posedge clk) begin
    if (reset) calc.target <= '0;
    else calc.target <= next_target;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_never_above_ceiling;
    !$past(reset) |-> (calc.target[0] <= $past(calc.ceiling[0])) && (calc.target[1] <= $past(calc.ceiling[1]));
  endproperty
  a_never_above_ceiling: assert property (p_never_above_ceiling) else $error("target above ceiling");

  property p_sum_passes;
    (!reset && calc.trim[0] == 16'h0000 && calc.command[0] <= calc.ceiling[0])
      |=> calc.target[0] == $past(calc.command[0]);
  endproperty
  a_sum_passes: assert property (p_sum_passes) else $error("target differs from command with zero trim");

  property p_trim_offset;
    (calc.trim[1] == 16'h0064 && calc.command[1] == 16'h0320 && calc.ceiling[1] >= 16'h0384)
      |=> calc.target[1] == 16'h0384;
  endproperty
  a_trim_offset: assert property (p_trim_offset) else $error("positive trim not added");

  property p_trim_negative_clip;
    (calc.trim[0] == 16'hFC18 && calc.command[0] == 16'h0400 && calc.ceiling[0] >= 16'h0400)
      |=> calc.target[0] == 16'h0306;
  endproperty
  a_trim_negative_clip: assert property (p_trim_negative_clip) else $error("negative trim not clipped");

endmodule : target_limiter
`default_nettype wire

// >>> core/output_trim_offset_limit_regs.sv
// paged trim and ceiling registers feeding the output voltage target
`timescale 1ns/1ps
`default_nettype none
// Operation
// - trim is a signed millivolt offset on the command, within plus or minus 250
// - trim resets to zero so no offset applies until written
// - the target never exceeds the ceiling value held one cycle earlier
// - ceiling resets to 08FCh, meaning 2300 millivolts
// - both words kept per page, sixteen bits written and read back
module output_trim_offset_limit_regs
  import vout_regs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [CMD_W-1:0] cmd_code,
  input wire logic [PAGE_W-1:0] page_sel,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [NUM_PAGES-1:0][DATA_W-1:0] vout_command,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic cmd_unsupported,
  output logic [NUM_PAGES-1:0][DATA_W-1:0] vout_target
);

  logic [NUM_PAGES-1:0][DATA_W-1:0] trim_offset;
  logic [NUM_PAGES-1:0][DATA_W-1:0] target_ceiling;

  wire hit_trim = (cmd_code == CMD_TRIM_OFFSET);
  wire hit_ceiling = (cmd_code == CMD_TARGET_CEILING);
  wire hit_any = hit_trim || hit_ceiling;
  wire wr_trim = wr_en && hit_trim;
  wire wr_ceiling = wr_en && hit_ceiling;
  wire [DATA_W-1:0] read_word = hit_trim ? trim_offset[page_sel] :
                                hit_ceiling ? target_ceiling[page_sel] : '0;
  // a code outside this bank is answered with zero and flagged for the protocol engine
  wire next_unsupported = (wr_en || rd_en) && !hit_any;

  always_ff @(posedge clk) begin
    if (reset) begin
      trim_offset <= {NUM_PAGES{TRIM_RESET}};
      target_ceiling <= {NUM_PAGES{CEILING_RESET}};
    end else begin
      if (wr_trim) trim_offset[page_sel] <= wr_data;
      if (wr_ceiling) target_ceiling[page_sel] <= wr_data;
    end
  end

  // read data registered; a same-cycle write is not yet visible to the read
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
      cmd_unsupported <= 1'b0;
    end else begin
      rd_data <= rd_en ? read_word : rd_data;
      rd_valid <= rd_en;
      cmd_unsupported <= next_unsupported;
    end
  end

  target_calc_if calc_bus ();

  assign calc_bus.command = vout_command;
  assign calc_bus.trim = trim_offset;
  assign calc_bus.ceiling = target_ceiling;
  assign vout_target = calc_bus.target;

  target_limiter u_limiter (
    .clk(clk),
    .reset(reset),
    .calc(calc_bus.calc)
  );

  default clocking cb @(posedge clk); endclocking

  property p_trim_reset;
    $past(reset) && !reset |-> trim_offset[0] == 16'h0000 && trim_offset[1] == 16'h0000;
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim not zero after reset");

  property p_ceiling_reset;
    $past(reset) && !reset |-> target_ceiling[0] == 16'h08FC && target_ceiling[1] == 16'h08FC;
  endproperty
  a_ceiling_reset: assert property (p_ceiling_reset) else $error("ceiling not 08FC after reset");

  property p_write_read_back;
    logic [DATA_W-1:0] d;
    logic [CMD_W-1:0] c;
    logic [PAGE_W-1:0] pg;
    disable iff (reset)
    (wr_en && hit_any, d = wr_data, c = cmd_code, pg = page_sel)
      ##1 (rd_en && !wr_en && cmd_code == c && page_sel == pg) |=> rd_valid && rd_data == d;
  endproperty
  a_write_read_back: assert property (p_write_read_back) else $error("read back differs from write");

  property p_pages_separate;
    disable iff (reset)
    (wr_en && hit_trim && page_sel == 1'b0) |=> $stable(trim_offset[1]);
  endproperty
  a_pages_separate: assert property (p_pages_separate) else $error("write leaked to other page");

  // bus-side checks lean on the package codes, not on the decode wires above,
  // so a broken decode cannot hide behind its own expression

  property p_rd_valid_follows;
    disable iff (reset)
    rd_en |=> rd_valid;
  endproperty
  a_rd_valid_follows: assert property (p_rd_valid_follows)
    else $error("no read strobe after a read request");

  property p_rd_valid_only_on_request;
    disable iff (reset)
    !rd_en |=> !rd_valid;
  endproperty
  a_rd_valid_only_on_request: assert property (p_rd_valid_only_on_request)
    else $error("read strobe without a read request");

  property p_rd_data_holds;
    disable iff (reset)
    !rd_en |=> $stable(rd_data);
  endproperty
  a_rd_data_holds: assert property (p_rd_data_holds)
    else $error("read word changed without a read");

  property p_trim_read_selects_page;
    disable iff (reset)
    rd_en && cmd_code == CMD_TRIM_OFFSET |=> rd_data == $past(trim_offset[page_sel]);
  endproperty
  a_trim_read_selects_page: assert property (p_trim_read_selects_page)
    else $error("trim read returned the wrong page");

  property p_ceiling_read_selects_page;
    disable iff (reset)
    rd_en && cmd_code == CMD_TARGET_CEILING |=> rd_data == $past(target_ceiling[page_sel]);
  endproperty
  a_ceiling_read_selects_page: assert property (p_ceiling_read_selects_page)
    else $error("ceiling read returned the wrong page");

  property p_unmapped_read_zero;
    disable iff (reset)
    rd_en && cmd_code != CMD_TRIM_OFFSET && cmd_code != CMD_TARGET_CEILING |=> rd_data == 16'h0000;
  endproperty
  a_unmapped_read_zero: assert property (p_unmapped_read_zero)
    else $error("unmapped read did not return zero");

  property p_unmapped_flagged;
    disable iff (reset)
    (wr_en || rd_en) && cmd_code != CMD_TRIM_OFFSET && cmd_code != CMD_TARGET_CEILING |=> cmd_unsupported;
  endproperty
  a_unmapped_flagged: assert property (p_unmapped_flagged)
    else $error("unmapped access not flagged");

  property p_mapped_not_flagged;
    disable iff (reset)
    !(wr_en || rd_en) || cmd_code == CMD_TRIM_OFFSET || cmd_code == CMD_TARGET_CEILING |=> !cmd_unsupported;
  endproperty
  a_mapped_not_flagged: assert property (p_mapped_not_flagged)
    else $error("flag raised without an unmapped access");

  property p_unmapped_write_ignored;
    disable iff (reset)
    wr_en && cmd_code != CMD_TRIM_OFFSET && cmd_code != CMD_TARGET_CEILING
      |=> $stable(trim_offset) && $stable(target_ceiling);
  endproperty
  a_unmapped_write_ignored: assert property (p_unmapped_write_ignored)
    else $error("unmapped write changed a register");

  property p_trim_write_lands;
    logic [DATA_W-1:0] d;
    logic [PAGE_W-1:0] pg;
    disable iff (reset)
    (wr_en && cmd_code == CMD_TRIM_OFFSET, d = wr_data, pg = page_sel) |=> trim_offset[pg] == d;
  endproperty
  a_trim_write_lands: assert property (p_trim_write_lands)
    else $error("trim write did not land");

  property p_ceiling_write_lands;
    logic [DATA_W-1:0] d;
    logic [PAGE_W-1:0] pg;
    disable iff (reset)
    (wr_en && cmd_code == CMD_TARGET_CEILING, d = wr_data, pg = page_sel) |=> target_ceiling[pg] == d;
  endproperty
  a_ceiling_write_lands: assert property (p_ceiling_write_lands)
    else $error("ceiling write did not land");

  property p_trim_page1_keeps_page0;
    disable iff (reset)
    wr_en && cmd_code == CMD_TRIM_OFFSET && page_sel == 1'b1 |=> $stable(trim_offset[0]);
  endproperty
  a_trim_page1_keeps_page0: assert property (p_trim_page1_keeps_page0)
    else $error("trim write leaked into page zero");

  property p_ceiling_page0_keeps_page1;
    disable iff (reset)
    wr_en && cmd_code == CMD_TARGET_CEILING && page_sel == 1'b0 |=> $stable(target_ceiling[1]);
  endproperty
  a_ceiling_page0_keeps_page1: assert property (p_ceiling_page0_keeps_page1)
    else $error("ceiling write leaked into page one");

  property p_ceiling_page1_keeps_page0;
    disable iff (reset)
    wr_en && cmd_code == CMD_TARGET_CEILING && page_sel == 1'b1 |=> $stable(target_ceiling[0]);
  endproperty
  a_ceiling_page1_keeps_page0: assert property (p_ceiling_page1_keeps_page0)
    else $error("ceiling write leaked into page zero");

  // reset checks carry no disable: they must hold while reset is high
  property p_reset_defaults;
    reset |=> trim_offset[0] == 16'h0000 && trim_offset[1] == 16'h0000
      && target_ceiling[0] == 16'h08FC && target_ceiling[1] == 16'h08FC;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("registers leave their defaults during reset");

  property p_reset_bus_outputs;
    reset |=> rd_data == 16'h0000 && !rd_valid && !cmd_unsupported;
  endproperty
  a_reset_bus_outputs: assert property (p_reset_bus_outputs)
    else $error("bus outputs not cleared by reset");

  property p_reset_target;
    reset |=> vout_target[0] == 16'h0000 && vout_target[1] == 16'h0000;
  endproperty
  a_reset_target: assert property (p_reset_target)
    else $error("target not cleared by reset");

  // the reset term keeps the edge that releases reset from expecting a live target
  property p_page1_sum_passes;
    disable iff (reset)
    !reset && trim_offset[1] == 16'h0000 && vout_command[1] <= target_ceiling[1]
      |=> vout_target[1] == $past(vout_command[1]);
  endproperty
  a_page1_sum_passes: assert property (p_page1_sum_passes)
    else $error("page one target differs from command with zero trim");

endmodule : output_trim_offset_limit_regs
`default_nettype wire

// >>> sim/mgmt_host.sv
// host model issuing word writes and reads
`timescale 1ns/1ps
`default_nettype none
module mgmt_host
  import vout_regs_pkg::*;
(
  input wire logic clk,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_valid,
  output logic wr_en,
  output logic rd_en,
  output logic [CMD_W-1:0] cmd_code,
  output logic [PAGE_W-1:0] page_sel,
  output logic [DATA_W-1:0] wr_data
);
  initial {wr_en, rd_en, cmd_code, page_sel, wr_data} = '0;
  task automatic write(input logic [7:0] c, input logic p, input logic [15:0] d);
    // ceilings above 3300 are never sent
    if (c == CMD_TARGET_CEILING && d > 16'h0CE4) return;
    @(posedge clk);
    {wr_en, cmd_code, page_sel, wr_data} <= {1'b1, c, p, d};
    @(posedge clk);
    wr_en <= 1'b0;
    // no stale word left on the data lines
    wr_data <= ~d;
  endtask : write
  task automatic read(input logic [7:0] c, input logic p, output logic [15:0] d, output logic v);
    @(posedge clk);
    {rd_en, cmd_code, page_sel} <= {1'b1, c, p};
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_valid;
    d = rd_data;
  endtask : read
  // write, then read the same word on the very next edge
  task automatic write_read(input logic [7:0] c, input logic p, input logic [15:0] d, output logic [15:0] q,
                            output logic v);
    @(posedge clk);
    {wr_en, cmd_code, page_sel, wr_data} <= {1'b1, c, p, d};
    @(posedge clk);
    {wr_en, rd_en} <= 2'b01;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_valid;
    q = rd_data;
  endtask : write_read
endmodule : mgmt_host
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the trim and ceiling register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
  import vout_regs_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wr_en, rd_en, rd_valid, cmd_unsupported, rd_ok;
  logic [CMD_W-1:0] cmd_code;
  logic [PAGE_W-1:0] page_sel;
  logic [DATA_W-1:0] wr_data, rd_data, rd_word;
  logic [NUM_PAGES-1:0][DATA_W-1:0] vout_command = '0;
  logic [NUM_PAGES-1:0][DATA_W-1:0] vout_target;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  output_trim_offset_limit_regs dut (.clk(clk), .reset(reset), .wr_en(wr_en), .rd_en(rd_en), .cmd_code(cmd_code),
    .page_sel(page_sel), .wr_data(wr_data), .vout_command(vout_command), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmd_unsupported(cmd_unsupported), .vout_target(vout_target));
  mgmt_host host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .wr_en(wr_en), .rd_en(rd_en),
    .cmd_code(cmd_code), .page_sel(page_sel), .wr_data(wr_data));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_rd(input logic [7:0] c, input logic p, input logic [15:0] e);
    host.read(c, p, rd_word, rd_ok);
    chk("rd_valid", 16'h0001, {15'h0000, rd_ok});
    chk("rd_data", e, rd_word);
    chk("cmd_unsupported", {15'h0000, c != CMD_TRIM_OFFSET && c != CMD_TARGET_CEILING},
      {15'h0000, cmd_unsupported});
  endtask : chk_rd
  task automatic chk_wr_rd(input logic [7:0] c, input logic p, input logic [15:0] d);
    host.write_read(c, p, d, rd_word, rd_ok);
    chk("rd_valid", 16'h0001, {15'h0000, rd_ok});
    chk("rd_data", d, rd_word);
  endtask : chk_wr_rd
  task automatic chk_tgt(input logic p, input logic [15:0] e);
    repeat (TARGET_LATENCY + 1) @(posedge clk);
    #1;
    chk("vout_target", e, vout_target[p]);
  endtask : chk_tgt
  task automatic test_reset_values();
    for (int p = 0; p < NUM_PAGES; p++) begin
      chk_rd(CMD_TRIM_OFFSET, p[0], TRIM_RESET);
      chk_rd(CMD_TARGET_CEILING, p[0], CEILING_RESET);
    end
  endtask : test_reset_values
  task automatic test_readback();
    host.write(CMD_TRIM_OFFSET, 1'b1, 16'hA5C3);
    host.write(CMD_TARGET_CEILING, 1'b0, 16'h0CE4);
    // an unmapped write is flagged and must leave every word alone
    host.write(8'h23, 1'b0, 16'h1234);
    #1;
    chk("cmd_unsupported", 16'h0001, {15'h0000, cmd_unsupported});
    chk_rd(CMD_TRIM_OFFSET, 1'b1, 16'hA5C3);
    chk_rd(CMD_TRIM_OFFSET, 1'b0, 16'h0000);
    chk_rd(CMD_TARGET_CEILING, 1'b0, 16'h0CE4);
    chk_rd(CMD_TARGET_CEILING, 1'b1, 16'h08FC);
    // unmapped code reads as zero
    chk_rd(8'h23, 1'b0, 16'h0000);
  endtask : test_readback
  task automatic test_trim();
    @(posedge clk);
    vout_command <= {16'h0800, 16'h0400};
    chk_tgt(0, 16'h0400);
    host.write(CMD_TRIM_OFFSET, 1'b0, 16'hFC18);
    chk_tgt(0, 16'h0306);
    host.write(CMD_TRIM_OFFSET, 1'b0, 16'hFF9C);
    chk_tgt(0, 16'h039C);
    host.write(CMD_TRIM_OFFSET, 1'b0, 16'h00FA);
    chk_tgt(0, 16'h04FA);
    chk_tgt(1, 16'h0706);
  endtask : test_trim
  task automatic test_ceiling();
    host.write(CMD_TARGET_CEILING, 1'b0, 16'h0500);
    @(posedge clk);
    vout_command[0] <= 16'h04F0;
    chk_tgt(0, 16'h0500);
    host.write(CMD_TARGET_CEILING, 1'b0, 16'h0000);
    chk_tgt(0, 16'h0000);
    chk_tgt(1, 16'h0706);
  endtask : test_ceiling
  task automatic test_page_one();
    chk_wr_rd(CMD_TRIM_OFFSET, 1'b1, 16'h0064);
    @(posedge clk);
    vout_command[1] <= 16'h0320;
    chk_tgt(1, 16'h0384);
    // out-of-range ceiling is held back by the host and never reaches the bank
    host.write(CMD_TARGET_CEILING, 1'b1, 16'h0CE5);
    chk_rd(CMD_TARGET_CEILING, 1'b1, CEILING_RESET);
    chk_wr_rd(CMD_TARGET_CEILING, 1'b1, 16'h0300);
    chk_tgt(1, 16'h0300);
    chk_tgt(0, 16'h0000);
  endtask : test_page_one
  task automatic test_mid_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("vout_target", 16'h0000, vout_target[1]);
    chk("rd_data", 16'h0000, rd_data);
    @(posedge clk);
    reset <= 1'b0;
    chk_rd(CMD_TRIM_OFFSET, 1'b1, TRIM_RESET);
    chk_rd(CMD_TARGET_CEILING, 1'b1, CEILING_RESET);
    chk_tgt(0, 16'h04F0);
    chk_tgt(1, 16'h0320);
  endtask : test_mid_reset
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    test_reset_values();
    test_readback();
    test_trim();
    test_ceiling();
    test_page_one();
    test_mid_reset();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
